// >>> rtl/slew_prot_map.vh
// Purpose: Register offsets, field positions, reset values and step timing
//          for the slew tracking and protection status slice.
// Assumes: CLK_I is the shared master clock from the power manager.
// Notes:
// Notes on behaviour
// - Setpoint moves in 12.5mV steps; step duration sets the slew rate.
// - Step duration comes from dividing the master clock, no local oscillator.
// - All converters time ramps from the same shared master clock.
// - Rising code 0 is 0.1V/ms default, code 7 is 8.3V/ms, rising between.
// - Tracking config: bit7 zero, 6:4 rise, bit3 slew enable reset 1, 2:0 fall.
// - Keep over/undervoltage, current, temp, tracking, warning, power good status.
// - Status read-only: 7 warn,6 pg,5 track,4 temp,3 current,2 uv,1 ov,0 error.
// - Flags read 0 when active; reset all 1 except power good 0. Power good reads 1 when good.
// - Overcurrent during turn-on ramp trips protection and flags it.
// - Host writes current and protection limits; device applies them.
// - After turn-on, wait 0..255 ms delay code before ramping.
// - Off delay up to 63 ms includes ramp-down with slew, else ends at switch-off.
`ifndef SLEW_PROT_MAP_VH
`define SLEW_PROT_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OFS_TRACK_CFG   8'h00
`define OFS_PROT_STAT   8'h01
`define OFS_ON_DLY      8'h02
`define OFS_OFF_DLY     8'h03
`define OFS_CUR_LIM     8'h04
`define OFS_PROT_CFG2   8'h05

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define TC_RISE_HI      6
`define TC_RISE_LO      4
`define TC_SLEW_EN      3
`define TC_FALL_HI      2
`define TC_FALL_LO      0
`define TC_RST          8'h08
`define ST_RST          8'hBF
`define DON_RST         8'h00
`define DOF_RST         8'h00
`define CLS_RST         8'h1B
`define PC2_RST         8'h08
`define DOF_MASK        8'h3F
`define I2C_ADDR_RST    7'h20

// ----------------------------------------------------------------
// Timing: step size in uV, rates in mV/ms, clock period in ns
// ----------------------------------------------------------------
`define CLK_NS          40
`define STEP_UV         12500
`define MS_NS           1000000
`define RATE_0          100
`define RATE_1          200
`define RATE_2          500
`define RATE_3          1000
`define RATE_4          2000
`define RATE_5          3000
`define RATE_6          5000
`define RATE_7          8300

`endif

// >>> rtl/step_timer.v
// Purpose: Step period divider producing one-cycle step enables.
// Assumes: Period of at least two cycles.
// Notes:   Period is sampled only when a period begins.
`timescale 1ns/100ps
`default_nettype none
module step_timer (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        run_i,
  input  wire [11:0] period_i,
  output reg         step_o
);
  reg [11:0] count_ff;

  always @(posedge clk_i) begin
    if (rst_i) begin
      count_ff <= 12'h000;
      step_o   <= 1'b0;
    end else if (!run_i) begin
      count_ff <= period_i - 12'h001;
      step_o   <= 1'b0;
    end else if (count_ff == 12'h000) begin
      // Reload only at the boundary, no partial step
      count_ff <= period_i - 12'h001;
      step_o   <= 1'b1;
    end else begin
      count_ff <= count_ff - 12'h001;
      step_o   <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> rtl/slew_prot.v
// Purpose: Setpoint slewing, on/off sequencing, protection status and
//          the I2C register slave of a point-of-load converter.
// Assumes: CLK_I is the master clock; I2C pins synchronous to it.
// Notes:   Setpoint is in 12.5mV units.
`timescale 1ns/100ps
`default_nettype none
`include "slew_prot_map.vh"
module slew_prot #(
  parameter [20:0] MS_CYCLES = 21'd25000,
  parameter [6:0]  DEV_ADDR  = `I2C_ADDR_RST
) (
  input  wire       CLK_I,
  input  wire       SYS_RST_I,
  input  wire       SCL_I,
  input  wire       SDA_I,
  output reg        SDA_O,
  output reg        SDA_OE_O,
  input  wire       TURN_ON_I,
  input  wire       TURN_OFF_I,
  input  wire [9:0] VOUT_TARGET_I,
  input  wire       OVERVOLT_I,
  input  wire       UNDERVOLT_I,
  input  wire       OVERCURRENT_I,
  input  wire       OVERTEMP_I,
  input  wire       TEMP_WARN_I,
  input  wire       TRACK_FAULT_I,
  input  wire       VOLT_ERROR_I,
  output reg  [9:0] SETPOINT_O,
  output reg        SWITCH_EN_O,
  output reg  [7:0] CUR_LIMIT_O,
  output reg  [7:0] PROT_CFG_O
);
  // ----------------------------------------------------------------
  // Step period lookup
  // ----------------------------------------------------------------
  function [11:0] step_cycles;
    input [2:0] code;
    reg   [31:0] rate;
    reg   [31:0] tmp;
    begin
      case (code)
        3'h0:    rate = `RATE_0;
        3'h1:    rate = `RATE_1;
        3'h2:    rate = `RATE_2;
        3'h3:    rate = `RATE_3;
        3'h4:    rate = `RATE_4;
        3'h5:    rate = `RATE_5;
        3'h6:    rate = `RATE_6;
        default: rate = `RATE_7;
      endcase
      // Duration per 12.5mV step from master clock
      tmp         = (`STEP_UV * 1000 / rate) / `CLK_NS;
      step_cycles = tmp[11:0];
    end
  endfunction

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_ONDL = 3'h1;
  localparam [2:0] S_RUN  = 3'h2;
  localparam [2:0] S_OFDL = 3'h3;
  localparam [2:0] S_RDN  = 3'h4;

  localparam [2:0] I_IDLE = 3'h0;
  localparam [2:0] I_RX   = 3'h1;
  localparam [2:0] I_ACK  = 3'h2;
  localparam [2:0] I_TX   = 3'h3;
  localparam [2:0] I_MACK = 3'h4;

  reg  [7:0]  tracking_config_ff;
  reg  [7:0]  protection_status_ff;
  reg  [7:0]  turn_on_delay_ff;
  reg  [7:0]  turn_off_delay_ff;
  reg  [2:0]  state_ff;
  reg  [7:0]  ms_left_ff;
  reg  [20:0] ms_cnt_ff;
  reg  [20:0] off_rem_ff;
  reg         oc_hit_ff;
  reg         scl_q_ff;
  reg         sda_q_ff;
  reg  [2:0]  ist_ff;
  reg  [1:0]  kind_ff;
  reg  [3:0]  bit_cnt_ff;
  reg  [7:0]  shift_ff;
  reg  [7:0]  ptr_ff;
  reg         rd_ff;
  wire        step;
  wire        slew_on  = tracking_config_ff[`TC_SLEW_EN];
  wire [11:0] rise_per = step_cycles(
                  tracking_config_ff[`TC_RISE_HI:`TC_RISE_LO]);
  wire [11:0] fall_per = step_cycles(
                  tracking_config_ff[`TC_FALL_HI:`TC_FALL_LO]);
  wire        at_tgt   = (SETPOINT_O == VOUT_TARGET_I);
  // Fall period preloaded during the off delay, first step full length
  wire        going_dn = (state_ff == S_RDN) || (state_ff == S_OFDL) ||
                         (SETPOINT_O > VOUT_TARGET_I);
  wire        run_tmr  = (state_ff == S_RDN) ||
                         ((state_ff == S_RUN) && slew_on && !at_tgt);
  wire [21:0] ramp_need = {12'h000, SETPOINT_O} * {10'h000, fall_per};
  wire [28:0] off_prod  = (turn_off_delay_ff & `DOF_MASK) * MS_CYCLES;
  wire        scl_rise = SCL_I && !scl_q_ff;
  wire        scl_fall = !SCL_I && scl_q_ff;
  wire        start_c  = SCL_I && scl_q_ff && sda_q_ff && !SDA_I;
  wire        stop_c   = SCL_I && scl_q_ff && !sda_q_ff && SDA_I;

  function [7:0] reg_read;
    input [7:0] a;
    begin
      case (a)
        `OFS_TRACK_CFG: reg_read = tracking_config_ff & 8'h7F;
        `OFS_PROT_STAT: reg_read = protection_status_ff;
        `OFS_ON_DLY:    reg_read = turn_on_delay_ff;
        `OFS_OFF_DLY:   reg_read = turn_off_delay_ff & `DOF_MASK;
        `OFS_CUR_LIM:   reg_read = CUR_LIMIT_O;
        `OFS_PROT_CFG2: reg_read = PROT_CFG_O;
        default:        reg_read = 8'h00;
      endcase
    end
  endfunction

  wire [7:0]  rd_now   = reg_read(ptr_ff);

  // ----------------------------------------------------------------
  // Step divider, one shared master clock for every output
  // ----------------------------------------------------------------
  step_timer u_step (
    .clk_i    (CLK_I),
    .rst_i    (SYS_RST_I),
    .run_i    (run_tmr),
    .period_i (going_dn ? fall_per : rise_per),
    .step_o   (step)
  );

  // ----------------------------------------------------------------
  // Sequencer and setpoint
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      state_ff    <= S_IDLE;
      SETPOINT_O  <= 10'h000;
      SWITCH_EN_O <= 1'b0;
      ms_left_ff  <= 8'h00;
      ms_cnt_ff   <= 21'h000000;
      off_rem_ff  <= 21'h000000;
      oc_hit_ff   <= 1'b0;
    end else begin
      // Trip latches only outside idle; a turn-on from idle clears it
      if (OVERCURRENT_I && state_ff != S_IDLE)
        oc_hit_ff <= 1'b1;
      else if (TURN_ON_I && state_ff == S_IDLE)
        oc_hit_ff <= 1'b0;
      if (OVERCURRENT_I && state_ff != S_IDLE) begin
        // Trips even mid-ramp
        state_ff    <= S_IDLE;
        SETPOINT_O  <= 10'h000;
        SWITCH_EN_O <= 1'b0;
      end else begin
        case (state_ff)
          S_IDLE: begin
            SETPOINT_O  <= 10'h000;
            SWITCH_EN_O <= 1'b0;
            if (TURN_ON_I) begin
              state_ff   <= S_ONDL;
              ms_left_ff <= turn_on_delay_ff;
              ms_cnt_ff  <= 21'h000000;
            end
          end
          S_ONDL: begin
            // Whole milliseconds from the 8-bit code
            if (ms_left_ff == 8'h00) begin
              state_ff    <= S_RUN;
              SWITCH_EN_O <= 1'b1;
            end else if (ms_cnt_ff == MS_CYCLES - 21'h000001) begin
              ms_cnt_ff  <= 21'h000000;
              ms_left_ff <= ms_left_ff - 8'h01;
            end else begin
              ms_cnt_ff <= ms_cnt_ff + 21'h000001;
            end
          end
          S_RUN: begin
            if (TURN_OFF_I) begin
              state_ff   <= S_OFDL;
              off_rem_ff <= off_prod[20:0];
            end else if (!at_tgt) begin
              if (!slew_on)
                SETPOINT_O <= VOUT_TARGET_I;
              else if (step && going_dn)
                SETPOINT_O <= SETPOINT_O - 10'h001;
              else if (step)
                SETPOINT_O <= SETPOINT_O + 10'h001;
            end
          end
          S_OFDL: begin
            if (off_rem_ff != 21'h000000)
              off_rem_ff <= off_rem_ff - 21'h000001;
            // Ramp timed to reach zero as the delay ends
            if (slew_on) begin
              if ({1'b0, off_rem_ff} <= ramp_need)
                state_ff <= S_RDN;
            end else if (off_rem_ff == 21'h000000) begin
              state_ff    <= S_IDLE;
              SETPOINT_O  <= 10'h000;
              SWITCH_EN_O <= 1'b0;
            end
          end
          S_RDN: begin
            if (SETPOINT_O == 10'h000) begin
              state_ff    <= S_IDLE;
              SWITCH_EN_O <= 1'b0;
            end else if (step) begin
              SETPOINT_O <= SETPOINT_O - 10'h001;
            end
          end
          default: state_ff <= S_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Protection status, active-low flags except power good, which reads 1 when good
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SYS_RST_I)
      protection_status_ff <= `ST_RST;
    else
      protection_status_ff <= {
        ~TEMP_WARN_I,
        (state_ff == S_RUN) && at_tgt && !UNDERVOLT_I && !OVERVOLT_I,
        ~TRACK_FAULT_I,
        ~OVERTEMP_I,
        ~(OVERCURRENT_I || oc_hit_ff),
        ~UNDERVOLT_I,
        ~OVERVOLT_I,
        ~VOLT_ERROR_I};
  end

  // ----------------------------------------------------------------
  // I2C slave: address, pointer byte, then data bytes
  // ----------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      scl_q_ff           <= 1'b1;
      sda_q_ff           <= 1'b1;
      ist_ff             <= I_IDLE;
      kind_ff            <= 2'h0;
      bit_cnt_ff         <= 4'h0;
      shift_ff           <= 8'h00;
      ptr_ff             <= 8'h00;
      rd_ff              <= 1'b0;
      SDA_O              <= 1'b0;
      SDA_OE_O           <= 1'b0;
      tracking_config_ff <= `TC_RST;
      turn_on_delay_ff   <= `DON_RST;
      turn_off_delay_ff  <= `DOF_RST;
      CUR_LIMIT_O        <= `CLS_RST;
      PROT_CFG_O         <= `PC2_RST;
    end else begin
      scl_q_ff <= SCL_I;
      sda_q_ff <= SDA_I;
      if (start_c) begin
        ist_ff     <= I_RX;
        kind_ff    <= 2'h0;
        bit_cnt_ff <= 4'h0;
        SDA_OE_O   <= 1'b0;
      end else if (stop_c) begin
        ist_ff   <= I_IDLE;
        SDA_OE_O <= 1'b0;
      end else if (scl_rise) begin
        case (ist_ff)
          I_RX: begin
            shift_ff   <= {shift_ff[6:0], SDA_I};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end
          I_TX:   bit_cnt_ff <= bit_cnt_ff + 4'h1;
          I_MACK: begin
            if (SDA_I)
              ist_ff <= I_IDLE;   // Host ended the read
            else
              ptr_ff <= ptr_ff + 8'h01;
          end
          default: ist_ff <= ist_ff;
        endcase
      end else if (scl_fall) begin
        case (ist_ff)
          I_RX: begin
            if (bit_cnt_ff == 4'h8) begin
              bit_cnt_ff <= 4'h0;
              SDA_OE_O   <= 1'b1;
              ist_ff     <= I_ACK;
              if (kind_ff == 2'h0) begin
                rd_ff <= shift_ff[0];
                if (shift_ff[7:1] != DEV_ADDR) begin
                  SDA_OE_O <= 1'b0;
                  ist_ff   <= I_IDLE;
                end
              end else if (kind_ff == 2'h1) begin
                ptr_ff <= shift_ff;
              end else begin
                ptr_ff <= ptr_ff + 8'h01;
                // Written limits drive the protection set
                case (ptr_ff)
                  `OFS_TRACK_CFG: tracking_config_ff <= shift_ff & 8'h7F;
                  `OFS_ON_DLY:    turn_on_delay_ff   <= shift_ff;
                  `OFS_OFF_DLY:   turn_off_delay_ff  <= shift_ff & `DOF_MASK;
                  `OFS_CUR_LIM:   CUR_LIMIT_O        <= shift_ff;
                  `OFS_PROT_CFG2: PROT_CFG_O         <= shift_ff;
                  default:        ptr_ff <= ptr_ff + 8'h01;
                endcase
              end
            end
          end
          I_ACK, I_MACK: begin
            if ((kind_ff == 2'h0 && rd_ff) || ist_ff == I_MACK) begin
              shift_ff <= rd_now;
              SDA_OE_O <= ~rd_now[7];
              ist_ff   <= I_TX;
            end else begin
              SDA_OE_O <= 1'b0;
              kind_ff  <= (kind_ff == 2'h0) ? 2'h1 : 2'h2;
              ist_ff   <= I_RX;
            end
            bit_cnt_ff <= 4'h0;
          end
          I_TX: begin
            if (bit_cnt_ff == 4'h8) begin
              SDA_OE_O <= 1'b0;
              ist_ff   <= I_MACK;
            end else begin
              SDA_OE_O <= ~shift_ff[6];
              shift_ff <= {shift_ff[6:0], 1'b0};
            end
          end
          default: SDA_OE_O <= 1'b0;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/slew_prot_props.sv
// Purpose: Port-level checks for the slew and protection slice.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to every slew_prot by the bind at the foot.
`timescale 1ns/100ps
`default_nettype none
module slew_prot_props (
  input wire logic       CLK_I,
  input wire logic       SYS_RST_I,
  input wire logic       SCL_I,
  input wire logic       TURN_ON_I,
  input wire logic [9:0] VOUT_TARGET_I,
  input wire logic       OVERCURRENT_I,
  input wire logic [9:0] SETPOINT_O,
  input wire logic       SWITCH_EN_O,
  input wire logic [7:0] CUR_LIMIT_O,
  input wire logic [7:0] PROT_CFG_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  // ------------------------------------------------
  // Cycles since the setpoint last moved
  // ------------------------------------------------
  logic [11:0] gap_ff;
  always @(posedge CLK_I) begin
    if (SYS_RST_I || $changed(SETPOINT_O)) gap_ff <= 12'h000;
    else if (gap_ff != 12'hFFF) gap_ff <= gap_ff + 12'h001;
  end
  property p_oc_trip;
    OVERCURRENT_I && SWITCH_EN_O |=> !SWITCH_EN_O && SETPOINT_O == 10'h000;
  endproperty
  a_oc_trip: assert property (p_oc_trip)
    else $error("overcurrent did not trip");
  property p_step_shape;
    $changed(SETPOINT_O) |-> SETPOINT_O == $past(SETPOINT_O) + 10'h001 ||
      SETPOINT_O == $past(SETPOINT_O) - 10'h001 ||
      SETPOINT_O == $past(VOUT_TARGET_I) || SETPOINT_O == 10'h000;
  endproperty
  a_step_shape: assert property (p_step_shape)
    else $error("setpoint moved by an odd amount");
  property p_step_gap;
    $changed(SETPOINT_O) && (SETPOINT_O == $past(SETPOINT_O) + 10'h001 ||
      SETPOINT_O == $past(SETPOINT_O) - 10'h001) |-> gap_ff >= 12'd36;
  endproperty
  a_step_gap: assert property (p_step_gap)
    else $error("step period shorter than fastest code");
  property p_off_zero;
    !SWITCH_EN_O |-> SETPOINT_O == 10'h000;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("setpoint nonzero with stage off");
  property p_fall_end;
    SWITCH_EN_O && SETPOINT_O == 10'h000 && $past(SETPOINT_O) == 10'h001
      |=> !SWITCH_EN_O;
  endproperty
  a_fall_end: assert property (p_fall_end)
    else $error("stage stayed on after ramp reached zero");
  property p_on_wait;
    TURN_ON_I && !SWITCH_EN_O |=> !SWITCH_EN_O;
  endproperty
  a_on_wait: assert property (p_on_wait)
    else $error("stage enabled without delay");
  property p_ramp_bound;
    $changed(SETPOINT_O) && SETPOINT_O == $past(SETPOINT_O) + 10'h001
      |-> SETPOINT_O <= $past(VOUT_TARGET_I);
  endproperty
  a_ramp_bound: assert property (p_ramp_bound)
    else $error("ramp passed its target");
  property p_cfg_update;
    $changed(CUR_LIMIT_O) || $changed(PROT_CFG_O) |-> !SCL_I;
  endproperty
  a_cfg_update: assert property (p_cfg_update)
    else $error("limit register changed with bus clock high");
endmodule
bind slew_prot slew_prot_props slew_prot_props_i (.CLK_I, .SYS_RST_I,
  .SCL_I, .TURN_ON_I, .VOUT_TARGET_I, .OVERCURRENT_I, .SETPOINT_O,
  .SWITCH_EN_O, .CUR_LIMIT_O, .PROT_CFG_O);
`default_nettype wire

// >>> tb/pwr_mgr_host.sv
// Purpose: Power manager model acting as bus host.
// Assumes: Open-drain bus, pull-up resolved by the bench.
// Notes:   Bit time is ten master clocks.
`timescale 1ns/100ps
`default_nettype none
module pwr_mgr_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_low_o
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic edge_sda(input logic low_first);
    sda_low_o = low_first;
    hold(4);
    scl_o = 1'b1;
    hold(4);
    sda_low_o = !low_first;
    hold(4);
  endtask
  // Data moves two clocks after the fall so the slave sees SCL low first
  task automatic bit_io(input logic b, output logic r);
    sda_low_o = !b;
    hold(4);
    scl_o = 1'b1;
    hold(2);
    r = sda_i;
    hold(2);
    scl_o = 1'b0;
    hold(2);
  endtask
  task automatic byte_io(input logic [7:0] tx, input logic ack_in,
                         output logic [7:0] rx, output logic ack_out);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack_in, ack_out);
  endtask
  // ------------------------------------------------
  // One register access
  // ------------------------------------------------
  task automatic xfer(input logic [6:0] addr, input logic is_rd,
                      input logic [7:0] ptr, wdat,
                      output logic [7:0] rdat, output logic nack);
    logic       a0, a1, a2;
    logic [7:0] junk;
    edge_sda(1'b0);
    scl_o = 1'b0;
    hold(2);
    byte_io({addr, 1'b0}, 1'b1, junk, a0);
    byte_io(ptr, 1'b1, junk, a1);
    rdat = 8'h00;
    if (is_rd) begin
      edge_sda(1'b0);
      scl_o = 1'b0;
      hold(2);
      byte_io({addr, 1'b1}, 1'b1, junk, a2);
      byte_io(8'hFF, 1'b1, rdat, junk[0]);
    end else begin
      byte_io(wdat, 1'b1, junk, a2);
    end
    edge_sda(1'b1);
    nack = a0 | a1 | a2;
  endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: Register and ramp tests for slew_prot.
// Assumes: Millisecond shortened to ten clocks.
// Notes:   Slew periods come from the rate table of the tracking codes.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic       clk, rst, turn_on, turn_off, sda_oe, sda_o, sw_en;
  logic       scl, host_low, nack;
  logic [7:0] faults, cur_lim, prot_cfg, rd;
  logic [9:0] target, setpt;
  int         bad_count, checks_done, cycles, n, c;
  int         per [8] = '{3125, 1562, 625, 312, 156, 104, 62, 37};
  wire        sda_w = !(host_low || sda_oe);
  // Device and host share one master clock
  slew_prot #(.MS_CYCLES(21'd10)) slew_prot_i (.CLK_I(clk),
    .SYS_RST_I(rst), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .TURN_ON_I(turn_on), .TURN_OFF_I(turn_off),
    .VOUT_TARGET_I(target), .OVERVOLT_I(faults[1]),
    .UNDERVOLT_I(faults[2]), .OVERCURRENT_I(faults[3]),
    .OVERTEMP_I(faults[4]), .TEMP_WARN_I(faults[7]),
    .TRACK_FAULT_I(faults[5]), .VOLT_ERROR_I(faults[0]),
    .SETPOINT_O(setpt), .SWITCH_EN_O(sw_en), .CUR_LIMIT_O(cur_lim),
    .PROT_CFG_O(prot_cfg));
  pwr_mgr_host pwr_mgr_host_i (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(host_low));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input string what, input logic [11:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic xfer(input logic is_rd, input logic [7:0] p, d);
    pwr_mgr_host_i.xfer(7'h20, is_rd, p, d, rd, nack);
    check("ack", 12'(nack), 12'h000);
  endtask
  task automatic rd_chk(input logic [7:0] p, exp);
    xfer(1'b1, p, 8'h00);
    check("register", 12'(rd), 12'(exp));
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  task automatic wait_step;
    logic [9:0] s;
    s = setpt;
    n = 0;
    while (setpt === s && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic wait_sw(input logic lvl);
    n = 0;
    while (sw_en !== lvl && n < 4000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    {rst, turn_on, turn_off, faults, target} = 21'h100000;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    rd_chk(8'h00, 8'h08);
    rd_chk(8'h01, 8'hBF);
    check("cur limit", 12'(cur_lim), 12'h01B);
    check("prot cfg", 12'(prot_cfg), 12'h008);
    check("sda out", 12'(sda_o), 12'h000);
    xfer(1'b0, 8'h00, 8'hFF);
    rd_chk(8'h00, 8'h7F);
    xfer(1'b0, 8'h01, 8'h00);
    rd_chk(8'h01, 8'hBF);
    rd_chk(8'h10, 8'h00);
    pwr_mgr_host_i.xfer(7'h21, 1'b0, 8'h00, 8'h00, rd, nack);
    check("foreign ack", 12'(nack), 12'h001);
    xfer(1'b0, 8'h04, 8'h05);
    check("cur limit", 12'(cur_lim), 12'h005);
    xfer(1'b0, 8'h05, 8'h03);
    check("prot cfg", 12'(prot_cfg), 12'h003);
    for (c = 0; c < 8; c++) if (c != 6 && c != 3) begin
      faults = 8'h01 << c;
      rd_chk(8'h01, 8'hBF & ~faults);
      faults = 8'h00;
    end
    // Fast rise with a 1 ms on delay and a 63 ms off delay
    xfer(1'b0, 8'h02, 8'h01);
    xfer(1'b0, 8'h03, 8'h3F);
    xfer(1'b0, 8'h00, 8'h7D);
    target = 10'd3;
    pulse(turn_on);
    wait_sw(1'b1);
    check("on delay", 12'(n >= 9 && n <= 13), 12'h001);
    wait_step();
    wait_step();
    check("rise period", 12'(n), 12'd37);
    wait_step();
    rd_chk(8'h01, 8'hFF);
    for (c = 0; c < 8; c++) begin
      xfer(1'b0, 8'h00, {1'b0, c[2:0], 1'b1, 3'd5});
      target = setpt + 10'd3;
      wait_step();
      wait_step();
      wait_step();
      check("step period", 12'(n), 12'(per[c]));
    end
    pulse(turn_off);
    wait_step();
    wait_step();
    check("fall period", 12'(n), 12'd104);
    wait_sw(1'b0);
    check("ramped off", 12'(setpt), 12'h000);
    xfer(1'b0, 8'h00, 8'h00);
    target = 10'd20;
    pulse(turn_on);
    wait_sw(1'b1);
    repeat (2) @(posedge clk);
    #1 check("jump", 12'(setpt), 12'd20);
    faults[3] = 1'b1;
    @(posedge clk);
    #1 check("trip", 12'({sw_en, setpt}), 12'h000);
    faults[3] = 1'b0;
    rd_chk(8'h01, 8'hB7);
    conclude();
  end
endmodule
`default_nettype wire
